// File: logic/si2c_channel.sv
// simplified i2c master channel: register port, bit engine and open-drain pins
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module si2c_channel (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [si2c_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [si2c_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [si2c_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic sda_i,
    output si2c_pkg::si2c_pin_t scl_o,
    output si2c_pkg::si2c_pin_t sda_o,
    output logic transfer_end_irq_o
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    si2c_pkg::si2c_state_t state_r;
    logic [2:0] sda_sync_r;
    logic sda_q_r;
    logic cks_r;
    logic txe_r;
    logic rxe_r;
    logic [si2c_pkg::DIV_W-1:0] div_r;
    logic [si2c_pkg::DIV_W-1:0] div_nxt;
    logic [si2c_pkg::PS_W-1:0] ps0_r;
    logic [si2c_pkg::PS_W-1:0] ps1_r;
    logic so_data_r;
    logic so_clk_r;
    logic soe_r;
    logic en_r;
    logic ack_err_r;
    logic [3:0] bit_cnt_r;
    logic [si2c_pkg::DIV_W-1:0] cnt_r;
    logic [si2c_pkg::BYTE_W-1:0] tx_sh_r;
    logic [si2c_pkg::BYTE_W-1:0] rx_sh_r;
    logic [si2c_pkg::BYTE_W-1:0] data_byte_r;
    logic frame_tx_r;
    logic frame_rx_r;
    logic irq_r;
    logic [si2c_pkg::DATA_W-1:0] rdata_r;
    logic tick0;
    logic tick1;
    logic op_en;
    logic half_tick;
    logic busy;
    logic wr_mode;
    logic wr_comm;
    logic wr_data;
    logic wr_out;
    logic wr_outen;
    logic wr_start;
    logic wr_stop;
    logic wr_clear;
    logic wr_presc;
    logic start_frame;
    logic frame_end;
    logic ack_slot;
    logic ack_lvl;
    logic bit_lvl;
    logic scl_lvl;
    logic sda_lvl;
    logic [si2c_pkg::DATA_W-1:0] rd_mux;

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    assign busy = (state_r != si2c_pkg::ST_IDLE);
    assign wr_mode = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_MODE);
    assign wr_comm = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_COMM);
    assign wr_data = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_DATA);
    assign wr_out = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_OUT);
    assign wr_outen = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_OUTEN);
    assign wr_start = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_START);
    assign wr_stop = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_STOP);
    assign wr_clear = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_CLEAR);
    assign wr_presc = reg_wr_i && (reg_addr_i == si2c_pkg::OFF_PRESC);

    // ---------------------------------------------------------------
    // clocking: two prescaler outputs, channel clock select, divider
    // ---------------------------------------------------------------
    si2c_presc u_presc0 (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sel_i(ps0_r),
        .tick_o(tick0)
    );

    si2c_presc u_presc1 (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sel_i(ps1_r),
        .tick_o(tick1)
    );

    assign op_en = cks_r ? tick1 : tick0;
    // each half of a bit lasts div+1 channel clocks, so the rate never passes a quarter of it
    assign half_tick = op_en && (cnt_r == div_r);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else if (!busy || half_tick) begin
            cnt_r <= '0;
        end else if (op_en) begin
            cnt_r <= cnt_r + 7'h01;
        end
    end

    // ---------------------------------------------------------------
    // data input synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sda_sync_r <= 3'h7;
        end else begin
            sda_sync_r <= {sda_sync_r[1:0], sda_i};
        end
    end

    // a level counts only once the second and third stages agree
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sda_q_r <= 1'b1;
        end else if (sda_sync_r[1] == sda_sync_r[2]) begin
            sda_q_r <= sda_sync_r[2];
        end
    end

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    // mode and layout writes are dropped mid-frame so a stray write cannot corrupt it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cks_r <= 1'b0;
        end else if (wr_mode && !busy) begin
            cks_r <= reg_wdata_i[si2c_pkg::MODE_CKS_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            txe_r <= 1'b0;
            rxe_r <= 1'b0;
        end else if (wr_comm) begin
            txe_r <= reg_wdata_i[si2c_pkg::COMM_TXE_BIT];
            rxe_r <= reg_wdata_i[si2c_pkg::COMM_RXE_BIT];
        end
    end

    assign div_nxt = reg_wdata_i[si2c_pkg::DIV_LSB +: si2c_pkg::DIV_W];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_r <= si2c_pkg::DIV_RESET;
        end else if (wr_data && !busy) begin
            div_r <= (div_nxt < si2c_pkg::DIV_MIN) ? si2c_pkg::DIV_MIN : div_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ps0_r <= si2c_pkg::PS_RESET;
            ps1_r <= si2c_pkg::PS_RESET;
        end else if (wr_presc && !busy) begin
            ps0_r <= reg_wdata_i[si2c_pkg::PS0_LSB +: si2c_pkg::PS_W];
            ps1_r <= reg_wdata_i[si2c_pkg::PS1_LSB +: si2c_pkg::PS_W];
        end
    end

    // ---------------------------------------------------------------
    // output levels, output enable, channel enable
    // ---------------------------------------------------------------
    // both lines idle released (high); software moves them for start and stop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            so_data_r <= 1'b1;
            so_clk_r <= 1'b1;
        end else if (start_frame) begin
            // the clock is parked low between frames so the slave holds its state
            so_clk_r <= 1'b0;
        end else if (wr_out && !busy) begin
            so_data_r <= reg_wdata_i[si2c_pkg::OUT_DATA_BIT];
            so_clk_r <= reg_wdata_i[si2c_pkg::OUT_CLK_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            soe_r <= 1'b0;
        end else if (wr_outen && !busy) begin
            soe_r <= reg_wdata_i[si2c_pkg::OUTEN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            en_r <= 1'b0;
        end else if (wr_start && reg_wdata_i[si2c_pkg::START_BIT]) begin
            en_r <= 1'b1;
        end else if (wr_stop && reg_wdata_i[si2c_pkg::STOP_BIT]) begin
            en_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // bit engine
    // ---------------------------------------------------------------
    assign start_frame = wr_data && en_r && !busy && (txe_r || rxe_r);
    assign ack_slot = (bit_cnt_r == si2c_pkg::ACK_INDEX);
    assign frame_end = (state_r == si2c_pkg::ST_HIGH) && half_tick && ack_slot;
    // receive-only frames pull the ack slot low, anything else releases it
    assign ack_lvl = !(frame_rx_r && !frame_tx_r);
    assign bit_lvl = ack_slot ? ack_lvl : tx_sh_r[si2c_pkg::BYTE_W-1];
    // with output enable off the pin shows the plain output bit, which suppresses the final ack
    assign sda_lvl = (busy && soe_r) ? bit_lvl : so_data_r;

    always_comb begin
        case (state_r)
            si2c_pkg::ST_LOW: scl_lvl = 1'b0;
            si2c_pkg::ST_HIGH: scl_lvl = 1'b1;
            si2c_pkg::ST_IDLE: scl_lvl = so_clk_r;
            default: scl_lvl = 1'b1;
        endcase
    end

    // the clock line is never read back: no arbitration and no stretch wait
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= si2c_pkg::ST_IDLE;
            bit_cnt_r <= '0;
            tx_sh_r <= si2c_pkg::BYTE_RESET;
            rx_sh_r <= si2c_pkg::BYTE_RESET;
            frame_tx_r <= 1'b0;
            frame_rx_r <= 1'b0;
        end else begin
            case (state_r)
                si2c_pkg::ST_IDLE: begin
                    if (start_frame) begin
                        // address and data frames are shifted the same way
                        tx_sh_r <= txe_r ? reg_wdata_i[si2c_pkg::BYTE_W-1:0] : si2c_pkg::BYTE_RESET;
                        bit_cnt_r <= '0;
                        frame_tx_r <= txe_r;
                        frame_rx_r <= rxe_r;
                        state_r <= si2c_pkg::ST_LOW;
                    end
                end
                si2c_pkg::ST_LOW: begin
                    if (half_tick) begin
                        state_r <= si2c_pkg::ST_HIGH;
                    end
                end
                si2c_pkg::ST_HIGH: begin
                    if (half_tick) begin
                        if (ack_slot) begin
                            state_r <= si2c_pkg::ST_IDLE;
                        end else begin
                            rx_sh_r <= {rx_sh_r[si2c_pkg::BYTE_W-2:0], sda_q_r};
                            tx_sh_r <= {tx_sh_r[si2c_pkg::BYTE_W-2:0], 1'b1};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            state_r <= si2c_pkg::ST_LOW;
                        end
                    end
                end
                default: begin
                    state_r <= si2c_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            data_byte_r <= si2c_pkg::BYTE_RESET;
        end else if (start_frame) begin
            data_byte_r <= reg_wdata_i[si2c_pkg::BYTE_W-1:0];
        end else if (frame_end && frame_rx_r) begin
            data_byte_r <= rx_sh_r;
        end
    end

    // ack sampled at the end of the ninth high phase; a high level is a missing ack
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_err_r <= 1'b0;
        end else if (frame_end && frame_tx_r && sda_q_r) begin
            ack_err_r <= 1'b1;
        end else if (wr_clear && reg_wdata_i[si2c_pkg::CLR_ACKERR_BIT]) begin
            ack_err_r <= 1'b0;
        end
    end

    // one source only: end of frame; there is no buffer-empty event at all
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= frame_end;
        end
    end

    // ---------------------------------------------------------------
    // pins: drive low or let go, never drive high
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_o <= '{out: 1'b0, oe: 1'b0};
            sda_o <= '{out: 1'b0, oe: 1'b0};
        end else begin
            // once stopped, the lines follow the output bits that software raises to release
            scl_o <= '{out: 1'b0, oe: !scl_lvl};
            sda_o <= '{out: 1'b0, oe: !sda_lvl};
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    always_comb begin
        rd_mux = '0;
        case (reg_addr_i)
            si2c_pkg::OFF_MODE: rd_mux = si2c_pkg::MODE_FIXED | (16'(cks_r) << si2c_pkg::MODE_CKS_BIT);
            si2c_pkg::OFF_COMM: begin
                rd_mux = si2c_pkg::COMM_FIXED;
                rd_mux[si2c_pkg::COMM_TXE_BIT] = txe_r;
                rd_mux[si2c_pkg::COMM_RXE_BIT] = rxe_r;
            end
            si2c_pkg::OFF_DATA: begin
                rd_mux[si2c_pkg::DIV_LSB +: si2c_pkg::DIV_W] = div_r;
                rd_mux[si2c_pkg::BYTE_W-1:0] = data_byte_r;
            end
            si2c_pkg::OFF_OUT: begin
                rd_mux[si2c_pkg::OUT_DATA_BIT] = so_data_r;
                rd_mux[si2c_pkg::OUT_CLK_BIT] = so_clk_r;
            end
            si2c_pkg::OFF_OUTEN: rd_mux[si2c_pkg::OUTEN_BIT] = soe_r;
            si2c_pkg::OFF_STATUS: begin
                rd_mux[si2c_pkg::ST_EN_BIT] = en_r;
                rd_mux[si2c_pkg::ST_BUSY_BIT] = busy;
                rd_mux[si2c_pkg::ST_ACKERR_BIT] = ack_err_r;
            end
            si2c_pkg::OFF_PRESC: begin
                rd_mux[si2c_pkg::PS0_LSB +: si2c_pkg::PS_W] = ps0_r;
                rd_mux[si2c_pkg::PS1_LSB +: si2c_pkg::PS_W] = ps1_r;
            end
            default: rd_mux = '0;
        endcase
    end

    // read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd_i ? rd_mux : '0;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign transfer_end_irq_o = irq_r;
endmodule : si2c_channel
`default_nettype wire

// File: common/si2c_pkg.sv
// shared constants, register layout and types of the simplified i2c master channel
package si2c_pkg;
    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFF_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_COMM = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_DATA = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_OUT = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_OUTEN = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_START = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_STOP = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h7;
    localparam logic [ADDR_W-1:0] OFF_CLEAR = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_PRESC = 4'h9;

    // ---------------------------------------------------------------
    // field positions and fixed patterns
    // ---------------------------------------------------------------
    localparam int MODE_CKS_BIT = 15;
    localparam logic [DATA_W-1:0] MODE_FIXED = 16'h0024;
    localparam int COMM_TXE_BIT = 15;
    localparam int COMM_RXE_BIT = 14;
    localparam logic [DATA_W-1:0] COMM_FIXED = 16'h0017;
    localparam int DIV_LSB = 9;
    localparam int DIV_W = 7;
    localparam int BYTE_W = 8;
    localparam int OUT_DATA_BIT = 0;
    localparam int OUT_CLK_BIT = 8;
    localparam int OUTEN_BIT = 0;
    localparam int START_BIT = 0;
    localparam int STOP_BIT = 0;
    localparam int ST_EN_BIT = 15;
    localparam int ST_BUSY_BIT = 6;
    localparam int ST_ACKERR_BIT = 1;
    localparam int CLR_ACKERR_BIT = 1;
    localparam int PS0_LSB = 0;
    localparam int PS1_LSB = 4;
    localparam int PS_W = 4;
    localparam int PRESC_CNT_W = 11;

    // ---------------------------------------------------------------
    // reset values and frame shape
    // ---------------------------------------------------------------
    localparam logic [DIV_W-1:0] DIV_RESET = 7'h01;
    localparam logic [DIV_W-1:0] DIV_MIN = 7'h01;
    localparam logic [PS_W-1:0] PS_RESET = 4'h0;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'hff;
    localparam logic [3:0] ACK_INDEX = 4'h8;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic out;
        logic oe;
    } si2c_pin_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b100
    } si2c_state_t;
endpackage : si2c_pkg

// File: logic/si2c_presc.sv
// one prescaler output: a tick every 2**sel cycles of the system clock, every 2**11 cycles at most
`timescale 1ns/1ps
`default_nettype none
module si2c_presc (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [si2c_pkg::PS_W-1:0] sel_i,
    output logic tick_o
);
    logic [si2c_pkg::PRESC_CNT_W-1:0] cnt_r;
    logic [si2c_pkg::PRESC_CNT_W-1:0] mask;

    // selections above the counter width saturate at the slowest rate
    assign mask = (sel_i >= 4'hb) ? 11'h7ff : 11'((12'h001 << sel_i) - 12'h001);
    assign tick_o = ((cnt_r & mask) == mask);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 11'h001;
        end
    end
endmodule : si2c_presc
`default_nettype wire

// File: tb/si2c_properties.sv
// port-level assertion checker for the simplified i2c master channel
`timescale 1ns/1ps
`default_nettype none
module si2c_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [si2c_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [si2c_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [si2c_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic sda_i,
    input wire si2c_pkg::si2c_pin_t scl_o,
    input wire si2c_pkg::si2c_pin_t sda_o,
    input wire logic transfer_end_irq_o
);
    // ---------------------------------------------------------------
    // software view of the channel, rebuilt from register writes
    // ---------------------------------------------------------------
    logic en_r, tx_r, rx_r, oen_r, busy_r, scl_q;
    logic [3:0] rel_r;
    logic [11:0] len_r;
    wire logic start_w = reg_wr_i && reg_addr_i == si2c_pkg::OFF_DATA && en_r && (tx_r || rx_r) && !busy_r;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            {en_r, tx_r, rx_r, oen_r} <= 4'h0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == si2c_pkg::OFF_START && reg_wdata_i[0]) en_r <= 1'b1;
            if (reg_addr_i == si2c_pkg::OFF_STOP && reg_wdata_i[0]) en_r <= 1'b0;
            if (reg_addr_i == si2c_pkg::OFF_COMM) {tx_r, rx_r} <= reg_wdata_i[15:14];
            if (reg_addr_i == si2c_pkg::OFF_OUTEN && !busy_r) oen_r <= reg_wdata_i[0];
        end
    end

    // clock releases in a frame, counted at the pin, which lags the engine
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy_r <= 1'b0;
            rel_r <= 4'h0;
        end else if (start_w) begin
            busy_r <= 1'b1;
            rel_r <= 4'h0;
        end else if (transfer_end_irq_o) begin
            busy_r <= 1'b0;
        end else if (busy_r && scl_q && !scl_o.oe) begin
            rel_r <= rel_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        scl_q <= sys_rst_i ? 1'b0 : scl_o.oe;
    end

    // cycles since frame start, saturating
    always_ff @(posedge clk_i) begin
        len_r <= (sys_rst_i || start_w) ? 12'h000 : len_r + 12'(len_r != 12'hfff);
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_ninth_release;
        busy_r && rel_r == 4'h8 && scl_q && !scl_o.oe;
    endsequence

    chk_pins_open_drain: assert property (!scl_o.out && !sda_o.out)
        else $error("pin driven high");
    chk_mode_fixed: assert property (reg_rd_i && reg_addr_i == si2c_pkg::OFF_MODE |=>
        (reg_rdata_o & 16'h7fff) == si2c_pkg::MODE_FIXED) else $error("mode fixed bits wrong");
    chk_irq_single_pulse: assert property (transfer_end_irq_o |=> !transfer_end_irq_o)
        else $error("transfer end pulse too long");
    chk_irq_in_frame: assert property (transfer_end_irq_o |-> busy_r)
        else $error("transfer end without a frame");
    chk_frame_length: assert property (busy_r && transfer_end_irq_o |-> len_r >= 12'h024 && len_r <= 12'hfa0)
        else $error("frame end out of range");
    chk_nine_clocks: assert property (busy_r && transfer_end_irq_o |-> rel_r == 4'h9)
        else $error("frame did not have nine clocks");
    chk_data_stable_high: assert property (busy_r && |rel_r && !scl_o.oe && !scl_q |-> $stable(sda_o.oe))
        else $error("data moved while clock high");
    chk_ack_released: assert property (s_ninth_release |-> !tx_r || !sda_o.oe)
        else $error("data held in ack slot");
    chk_ack_driven: assert property (s_ninth_release |-> tx_r || !rx_r || !oen_r || sda_o.oe)
        else $error("ack not driven on receive");
endmodule : si2c_properties

bind si2c_channel si2c_properties u_props (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .sda_i, .scl_o, .sda_o, .transfer_end_irq_o);
`default_nettype wire

// File: tb/si2c_slave_model.sv
// behavioural i2c slave: acks address and written bytes, returns a byte and its inverse on reads
`timescale 1ns/1ps
`default_nettype none
module si2c_slave_model #(
    parameter logic [7:0] RD_BYTE = 8'h96
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic ack_en_i,
    output logic pull_low_o,
    output logic [7:0] got_byte_o,
    output logic ack_seen_o
);
    int bit_n = 0;
    logic first_r = 1'b0;
    logic read_r = 1'b0;
    logic [7:0] sh = 8'h00;
    logic [7:0] rd_b = RD_BYTE;
    initial begin
        pull_low_o = 1'b0;
        got_byte_o = 8'h00;
        ack_seen_o = 1'b0;
    end
    // start: data falls while the clock is high
    always @(negedge sda_i) begin
        #1;
        if (scl_i === 1'b1) begin
            bit_n = 0;
            first_r = 1'b1;
            read_r = 1'b0;
            rd_b = RD_BYTE;
        end
    end
    always @(posedge scl_i) begin
        if (bit_n < 8) sh = {sh[6:0], sda_i};
        if (bit_n == 8) begin
            got_byte_o = sh;
            ack_seen_o = sda_i;
            if (first_r) read_r = sh[0];
            if (!first_r && read_r) rd_b = ~rd_b;
            // a refused read byte ends the slave's turn: release from then on
            if (!first_r && read_r && sda_i) read_r = 1'b0;
            first_r = 1'b0;
        end
        bit_n = (bit_n == 8) ? 0 : bit_n + 1;
    end
    // only ever pulls low, never drives high; changes only while the clock is low
    always @(negedge scl_i) begin
        if (bit_n == 8) pull_low_o = ack_en_i && !read_r;
        else pull_low_o = read_r && !rd_b[7 - bit_n];
    end
endmodule : si2c_slave_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench: register map, write and read frames against a slave model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [si2c_pkg::ADDR_W-1:0] reg_addr_i = 4'h0;
    logic [si2c_pkg::DATA_W-1:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [si2c_pkg::DATA_W-1:0] reg_rdata_o;
    si2c_pkg::si2c_pin_t scl_o;
    si2c_pkg::si2c_pin_t sda_o;
    logic transfer_end_irq_o, slave_low, ack_seen;
    logic ack_en = 1'b1;
    logic [7:0] got_byte;
    int errors = 0;
    int n_compared = 0;
    // open-drain wires with pull-ups
    wire logic scl_w = !scl_o.oe;
    wire logic sda_w = !(sda_o.oe || slave_low);

    always #5 clk_i = !clk_i;

    si2c_channel dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sda_i(sda_w), .scl_o(scl_o),
        .sda_o(sda_o), .transfer_end_irq_o(transfer_end_irq_o));
    si2c_slave_model slave (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en), .pull_low_o(slave_low),
        .got_byte_o(got_byte), .ack_seen_o(ack_seen));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input string what, input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(what, exp & m, reg_rdata_o & m);
    endtask : rd

    // one frame; probe pokes mode and status while busy, else the length is checked
    task automatic frame(input logic [6:0] dv, input logic [7:0] b, input bit probe, input int sh);
        int len;
        int h;
        len = 0;
        h = (int'(dv) + 1) << sh;
        wr(si2c_pkg::OFF_DATA, {dv, 1'b0, b});
        if (probe) begin
            wr(si2c_pkg::OFF_MODE, 16'h0000);
            rd("busy status", si2c_pkg::OFF_STATUS, 16'hffff, 16'h8040);
        end
        while (transfer_end_irq_o !== 1'b1 && len < 3000) begin
            @(posedge clk_i);
            #1;
            len++;
        end
        if (!probe) check("frame length", 16'h0001, {15'h0, len >= 18 * h - (1 << sh) && len <= 18 * h + 24});
    endtask : frame

    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd("mode reset", si2c_pkg::OFF_MODE, 16'hffff, 16'h0024);
        rd("comm reset", si2c_pkg::OFF_COMM, 16'hffff, 16'h0017);
        rd("data reset", si2c_pkg::OFF_DATA, 16'hfeff, 16'h02ff);
        rd("out reset", si2c_pkg::OFF_OUT, 16'h0101, 16'h0101);
        rd("outen reset", si2c_pkg::OFF_OUTEN, 16'h0001, 16'h0000);
        rd("status reset", si2c_pkg::OFF_STATUS, 16'hffff, 16'h0000);
        rd("presc reset", si2c_pkg::OFF_PRESC, 16'h00ff, 16'h0000);
        wr(4'hf, 16'hffff);
        rd("unmapped", 4'hf, 16'hffff, 16'h0000);
        wr(si2c_pkg::OFF_DATA, 16'h0000);
        rd("divider clamp", si2c_pkg::OFF_DATA, 16'hfe00, 16'h0200);
        $display("test registers done");
        wr(si2c_pkg::OFF_PRESC, 16'h0010);
        wr(si2c_pkg::OFF_START, 16'h0001);
        wr(si2c_pkg::OFF_COMM, 16'h8000);
        wr(si2c_pkg::OFF_OUT, 16'h0100);
        wr(si2c_pkg::OFF_OUTEN, 16'h0001);
        frame(7'h7c, 8'ha4, 1'b0, 0);
        check("address byte", 16'h00a4, {8'h00, got_byte});
        check("address ack", 16'h0000, {15'h0, ack_seen});
        rd("no ack error", si2c_pkg::OFF_STATUS, 16'h0002, 16'h0000);
        wr(si2c_pkg::OFF_MODE, 16'h8000);
        ack_en = 1'b0;
        frame(7'h3e, 8'h3c, 1'b0, 1);
        check("data byte", 16'h003c, {8'h00, got_byte});
        rd("ack error set", si2c_pkg::OFF_STATUS, 16'h0002, 16'h0002);
        wr(si2c_pkg::OFF_CLEAR, 16'h0002);
        rd("ack error clear", si2c_pkg::OFF_STATUS, 16'h0002, 16'h0000);
        ack_en = 1'b1;
        frame(7'h3e, 8'h5a, 1'b1, 1);
        rd("mode kept", si2c_pkg::OFF_MODE, 16'h8000, 16'h8000);
        $display("test write frames done");
        wr(si2c_pkg::OFF_OUTEN, 16'h0000);
        wr(si2c_pkg::OFF_OUT, 16'h0101);
        wr(si2c_pkg::OFF_OUT, 16'h0100);
        wr(si2c_pkg::OFF_OUTEN, 16'h0001);
        frame(7'h3e, 8'ha5, 1'b0, 1);
        wr(si2c_pkg::OFF_COMM, 16'h4000);
        frame(7'h3e, 8'hff, 1'b0, 1);
        rd("first read byte", si2c_pkg::OFF_DATA, 16'h00ff, 16'h0096);
        check("master ack", 16'h0000, {15'h0, ack_seen});
        wr(si2c_pkg::OFF_OUTEN, 16'h0000);
        wr(si2c_pkg::OFF_OUT, 16'h0001);
        frame(7'h3e, 8'hff, 1'b0, 1);
        rd("last read byte", si2c_pkg::OFF_DATA, 16'h00ff, 16'h0069);
        check("master nack", 16'h0001, {15'h0, ack_seen});
        wr(si2c_pkg::OFF_OUT, 16'h0000);
        wr(si2c_pkg::OFF_OUT, 16'h0100);
        wr(si2c_pkg::OFF_OUT, 16'h0101);
        wr(si2c_pkg::OFF_STOP, 16'h0001);
        rd("channel stopped", si2c_pkg::OFF_STATUS, 16'h8000, 16'h0000);
        check("bus released", 16'h0000, {14'h0, scl_o.oe, sda_o.oe});
        $display("test read frames done");
        finish_test();
    end

    // six frames of about 2300 cycles each; this allows ample margin
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        $display("unexpected watchdog: expected end of tests, seen timeout");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
